// ==== testbench/asu_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module asu_bench
  import asu_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ext, send_valid, send_ready, recv_valid;
  logic tx_empty_irq, tx_done_irq, rx_full_irq, rx_error_irq, recv_frame_err, recv_parity_err;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [1:0] bresp, rresp, rsp;
  logic [7:0] far_m, send_data, recv_data, m, d, x;
  logic [7:0] modes [5] = '{8'h00, 8'h12, 8'h07, 8'h29, 8'h18};
  logic [7:0] ctls [5] = '{8'h1F, 8'h3F, 8'h5F, 8'h1F, 8'h3F};
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  asu_if line_if ();
  asu_device #(.TICK_DIV_P(4)) asu_device_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq), .rx_full_irq(rx_full_irq),
    .rx_error_irq(rx_error_irq), .line(line_if));
  asu_partner #(.TICK_DIV_P(4)) asu_partner_inst (.aclk(aclk), .aresetn(aresetn),
    .cfg_seven(far_m[0]), .cfg_par_en(far_m[1]), .cfg_par_odd(far_m[2]), .cfg_mpf(far_m[3]),
    .cfg_two_stop(far_m[4]), .cfg_mpb(far_m[5]), .cfg_ext_clk(ext), .send_data(send_data),
    .send_valid(send_valid), .send_ready(send_ready), .recv_data(recv_data),
    .recv_valid(recv_valid), .recv_frame_err(recv_frame_err),
    .recv_parity_err(recv_parity_err), .line(line_if));
  asu_properties #(.TICK_DIV_P(4)) asu_properties_inst (.aclk(aclk), .aresetn(aresetn),
    .tx_data_pin(line_if.tx_data_pin), .rx_data_pin(line_if.rx_data_pin),
    .sck_dev_out(line_if.sck_dev_out), .sck_dev_oe(line_if.sck_dev_oe),
    .sck_far_out(line_if.sck_far_out), .sck_far_oe(line_if.sck_far_oe),
    .serial_clock_pin(line_if.serial_clock_pin));
  // Clock and watchdog
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      print_verdict();
    end
  end
  // Compare and bus access helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [4:0] a, input logic [31:0] mk, input logic [31:0] exp);
    rd(a);
    chk(rdv & mk, exp);
  endtask : rdc
  // Device and far-end format, then enables
  task automatic setup(input logic [7:0] md, input logic [7:0] mf, input logic [7:0] c);
    wr(OFF_CTRL, 32'h0);
    far_m <= mf;
    ext <= c[6];
    wr(OFF_MODE, {24'h0, md});
    wr(OFF_CTRL, {24'h0, c});
  endtask : setup
  task automatic dev_send(input logic [7:0] v);
    wr(OFF_TXDATA, {24'h0, v});
    wr(OFF_STATUS, 32'h3C);
  endtask : dev_send
  task automatic far_recv(input logic [7:0] exp);
    @(posedge aclk iff recv_valid);
    chk(recv_data, exp);
    chk({recv_frame_err, recv_parity_err}, 2'b00);
  endtask : far_recv
  task automatic far_send(input logic [7:0] v);
    @(posedge aclk);
    send_data <= v;
    send_valid <= 1'b1;
    @(posedge aclk iff send_ready);
    send_valid <= 1'b0;
  endtask : far_send
  task automatic err_case(input logic [7:0] md, mf, v, st);
    setup(md, mf, 8'h1F);
    far_send(v);
    @(posedge aclk iff rx_error_irq);
    rdc(OFF_STATUS, 32'h3C, {24'h0, st});
    rdc(OFF_RXDATA, 32'hFF, {24'h0, v});
    wr(OFF_STATUS, 32'h03);
  endtask : err_case
  task automatic print_verdict();
    $display("Checks: %0d, errors: %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ext, send_valid} = 8'h00;
    {awaddr, araddr, wdata, far_m, send_data} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(OFF_CTRL, 32'hFF, {24'h0, CTRL_RST});
    rdc(OFF_STATUS, 32'h3F, 32'h03);
    chk(rsp, RESP_OKAY);
    rd(5'h14);
    chk(rsp, RESP_SLVERR);
    wr(5'h18, 32'hFF);
    chk(rsp, RESP_SLVERR);
    for (int i = 0; i < 5; i++) begin
      m = modes[i];
      d = 8'h96 ^ 8'(i * 37);
      x = m[0] ? 8'h7F : 8'hFF;
      setup(m, m, ctls[i]);
      chk(tx_empty_irq, 1'b1);
      dev_send(d);
      far_recv(d & x);
      far_send(~d);
      @(posedge aclk iff rx_full_irq);
      rdc(OFF_STATUS, 32'h7C, {25'h0, m[3] & m[5], 6'h04});
      rdc(OFF_RXDATA, 32'hFF, {24'h0, ~d & x});
      wr(OFF_STATUS, 32'h3B);
      chk(rsp, RESP_OKAY);
    end
    setup(8'h00, 8'h00, 8'h1F);
    dev_send(8'h5A);
    @(posedge aclk iff tx_empty_irq);
    dev_send(8'hC3);
    chk(tx_done_irq, 1'b0);
    far_recv(8'h5A);
    far_recv(8'hC3);
    @(posedge aclk iff tx_done_irq);
    rdc(OFF_STATUS, 32'h03, 32'h03);
    far_send(8'h11);
    @(posedge aclk iff rx_full_irq);
    far_send(8'h22);
    @(posedge aclk iff rx_error_irq);
    rdc(OFF_STATUS, 32'h3C, 32'h0C);
    far_send(8'h33);
    repeat (800) @(posedge aclk);
    wr(OFF_CTRL, 32'h1D);
    rdc(OFF_STATUS, 32'h3C, 32'h0C);
    rdc(OFF_RXDATA, 32'hFF, 32'h11);
    wr(OFF_STATUS, 32'h03);
    err_case(8'h02, 8'h06, 8'h5C, 8'h20);
    err_case(8'h01, 8'h00, 8'h35, 8'h10);
    wr(OFF_CTRL, 32'h02);
    dev_send(8'hAA);
    rdc(OFF_STATUS, 32'h01, 32'h01);
    chk(line_if.tx_data_pin, 1'b1);
    print_verdict();
  end
endmodule : asu_bench
`default_nettype wire

// ==== testbench/asu_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module asu_properties #(
  parameter int unsigned TICK_DIV_P = 65
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial line
  input wire logic tx_data_pin,
  input wire logic rx_data_pin,
  input wire logic sck_dev_out,
  input wire logic sck_dev_oe,
  input wire logic sck_far_out,
  input wire logic sck_far_oe,
  input wire logic serial_clock_pin
);
  localparam int TD = TICK_DIV_P;
  localparam int BT = 16 * TICK_DIV_P;
  logic tx_q;
  logic rx_q;
  int tx_run;
  int rx_run;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles each line has held its level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_q <= 1'b1;
      rx_q <= 1'b1;
      tx_run <= BT;
      rx_run <= BT;
    end else begin
      tx_q <= tx_data_pin;
      rx_q <= rx_data_pin;
      tx_run <= (tx_data_pin != tx_q) ? 1 : tx_run + 1;
      rx_run <= (rx_data_pin != rx_q) ? 1 : rx_run + 1;
    end
  end
  // Line timing and clock pin use
  AST_IDLE_MARK:
  assert property ($rose(aresetn) |-> tx_data_pin && rx_data_pin) else $error("line not idle");
  AST_TX_LOW_RUN:
  assert property ($rose(tx_data_pin) |-> tx_run % BT == 0) else $error("tx bit length");
  AST_RX_LOW_RUN:
  assert property ($rose(rx_data_pin) |-> rx_run % BT == 0) else $error("rx bit length");
  AST_TX_HIGH_MIN:
  assert property ($fell(tx_data_pin) |-> tx_run >= BT) else $error("tx mark too short");
  AST_RX_HIGH_MIN:
  assert property ($fell(rx_data_pin) |-> rx_run >= BT) else $error("rx mark too short");
  AST_SCK_CENTRE:
  assert property ($rose(sck_dev_out) && sck_dev_oe && !tx_data_pin
    |-> tx_run % BT inside {[BT/2-TD:BT/2+TD]}) else $error("clock edge off centre");
  AST_EXT_CLK_RUNS:
  assert property (sck_far_oe && !sck_dev_oe |-> ##[1:TD] $changed(serial_clock_pin))
    else $error("external clock stopped");
  AST_NO_CONTENTION:
  assert property (!(sck_dev_oe && sck_far_oe)) else $error("clock pin contention");
  cover property ($fell(tx_data_pin));
  cover property ($rose(sck_dev_out) && sck_dev_oe);
  cover property ($changed(serial_clock_pin) && sck_far_oe);
endmodule : asu_properties
`default_nettype wire

// ==== verilog/asu_device.sv ====
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module asu_device
  import asu_pkg::*;
#(
  parameter int unsigned TICK_DIV_P = TICK_DIV
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt requests
  output logic tx_empty_irq,
  output logic tx_done_irq,
  output logic rx_full_irq,
  output logic rx_error_irq,
  // Serial line
  asu_if.device line
);

  localparam int DW = $clog2(TICK_DIV_P + 1);

  logic [7:0] ctrl, mode, tx_data_reg, rx_data_reg;
  logic tx_buf_empty, tx_done_flag, rx_buf_full, overrun_flag, frame_error_flag;
  logic parity_error_flag, rx_mpb;
  logic aw_held, w_held;
  logic [4:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_wr;
  logic [DW-1:0] div_cnt;
  logic div_tick, sck_prev, tick, bit_end;
  logic [3:0] ph;
  asu_state_t tx_st, rx_st;
  logic [7:0] tx_shift_reg, rx_shift_reg, tx_word, rx_word;
  logic [2:0] tx_idx, rx_idx;
  logic tx_x, rx_x, rx_prev;
  logic [3:0] rx_cnt;
  logic tx_load, tx_fin, last_stop, rx_end, err_any, perr, ferr;
  logic wr_ctrl, wr_mode, wr_status, wr_tx;

  // Configuration views
  wire tx_enable = ctrl[CB_TX_EN];
  wire rx_enable = ctrl[CB_RX_EN];
  wire [1:0] clk_sel = {ctrl[CB_CKS_HI], ctrl[CB_CKS_LO]};
  wire char_length_sel = mode[MB_SEVEN];
  wire parity_enable = mode[MB_PAR_EN];
  wire parity_odd_sel = mode[MB_PAR_ODD];
  wire multiproc_format = mode[MB_MPF];
  wire two_stop = mode[MB_TWO_STOP];
  wire extra_en = parity_enable | multiproc_format;
  wire [2:0] last_idx = char_length_sel ? 3'h6 : 3'h7;

  // Address hit test
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction : hit

  // Register read view
  function automatic logic [8:0] rd_mux(input logic [4:0] a);
    rd_mux = 9'h000;
    if (hit(a, OFF_CTRL)) rd_mux = {1'b1, ctrl};
    else if (hit(a, OFF_MODE)) rd_mux = {1'b1, mode};
    else if (hit(a, OFF_STATUS)) rd_mux = {2'b10, rx_mpb, parity_error_flag,
      frame_error_flag, overrun_flag, rx_buf_full, tx_done_flag, tx_buf_empty};
    else if (hit(a, OFF_TXDATA)) rd_mux = {1'b1, tx_data_reg};
    else if (hit(a, OFF_RXDATA)) rd_mux = {1'b1, rx_data_reg};
  endfunction : rd_mux

  // Write channel handshake
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_wr = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl = do_wr && w_strb_q[0] && hit(aw_addr_q, OFF_CTRL);
  assign wr_mode = do_wr && w_strb_q[0] && hit(aw_addr_q, OFF_MODE);
  assign wr_status = do_wr && w_strb_q[0] && hit(aw_addr_q, OFF_STATUS);
  assign wr_tx = do_wr && w_strb_q[0] && hit(aw_addr_q, OFF_TXDATA);

  // Write address, data and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 5'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (rd_mux(aw_addr_q) >> 8) != 9'h000 ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel, one cycle answer
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, 8'(rd_mux(s_axi_araddr))};
      s_axi_rresp <= rd_mux(s_axi_araddr) >= 9'h100 ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Software-written registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RST;
      mode <= MODE_RST;
      tx_data_reg <= DATA_RST;
    end else begin
      if (wr_ctrl) ctrl <= w_data_q[7:0];
      if (wr_mode) mode <= w_data_q[7:0];
      if (wr_tx) tx_data_reg <= w_data_q[7:0];
    end
  end

  // 16x tick: internal divider or external clock rise
  assign div_tick = (div_cnt == DW'(TICK_DIV_P - 1));
  assign tick = clk_sel[1] ? (line.serial_clock_pin && !sck_prev) : div_tick;
  assign bit_end = tick && (ph == LAST_PH);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= '0;
      sck_prev <= 1'b1;
      ph <= 4'h0;
    end else begin
      div_cnt <= div_tick ? '0 : div_cnt + 1'b1;
      sck_prev <= line.serial_clock_pin;
      if (tick) ph <= ph + 4'h1;
    end
  end

  // Bit clock out, rising edge at bit centre
  assign line.sck_dev_out = ph[3];
  assign line.sck_dev_oe = (clk_sel == CKS_INT_OUT);

  // Transmit control
  assign tx_word = asu_word(tx_data_reg, char_length_sel);
  assign last_stop = (tx_st == ST_STOP2) || (tx_st == ST_STOP1 && !two_stop);
  assign tx_load = bit_end && tx_enable && !tx_buf_empty &&
    (tx_st == ST_IDLE || last_stop);
  assign tx_fin = bit_end && tx_enable && tx_buf_empty && last_stop;

  // Transmit shifter and line
  always_ff @(posedge aclk) begin
    if (!aresetn || !tx_enable) begin
      tx_st <= ST_IDLE;
      tx_shift_reg <= DATA_RST;
      tx_idx <= 3'h0;
      tx_x <= 1'b1;
      line.tx_data_pin <= 1'b1;
    end else if (tx_load) begin
      tx_st <= ST_START;
      tx_shift_reg <= tx_word;
      tx_x <= multiproc_format ? mode[MB_MPB] : asu_par(tx_word, parity_odd_sel);
      line.tx_data_pin <= 1'b0;
    end else if (bit_end) begin
      case (tx_st)
        ST_START: begin
          tx_st <= ST_DATA;
          tx_idx <= 3'h0;
          line.tx_data_pin <= tx_shift_reg[0];
        end
        ST_DATA: begin
          if (tx_idx == last_idx) begin
            tx_st <= extra_en ? ST_EXTRA : ST_STOP1;
            line.tx_data_pin <= extra_en ? tx_x : 1'b1;
          end else begin
            tx_idx <= tx_idx + 3'h1;
            line.tx_data_pin <= tx_shift_reg[tx_idx + 3'h1];
          end
        end
        ST_EXTRA: begin
          tx_st <= ST_STOP1;
          line.tx_data_pin <= 1'b1;
        end
        ST_STOP1: tx_st <= two_stop ? ST_STOP2 : ST_IDLE;
        ST_STOP2: tx_st <= ST_IDLE;
        default: begin
          tx_st <= ST_IDLE;
          line.tx_data_pin <= 1'b1;
        end
      endcase
    end
  end

  // Transmit flags, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf_empty <= 1'b1;
      tx_done_flag <= 1'b1;
    end else begin
      if (tx_load || !tx_enable) tx_buf_empty <= 1'b1;
      else if (wr_status && !w_data_q[SB_TX_EMPTY]) tx_buf_empty <= 1'b0;
      if (tx_fin) tx_done_flag <= 1'b1;
      else if (wr_status && !w_data_q[SB_TX_DONE]) tx_done_flag <= 1'b0;
    end
  end

  // Receive checks
  assign err_any = overrun_flag | frame_error_flag | parity_error_flag;
  assign rx_word = char_length_sel ? {1'b0, rx_shift_reg[7:1]} : rx_shift_reg;
  assign perr = parity_enable && !multiproc_format &&
    (asu_par(rx_word, parity_odd_sel) != rx_x);
  assign ferr = !line.rx_data_pin;
  assign rx_end = tick && rx_enable && rx_st == ST_STOP1 && rx_cnt == SAMPLE_PH;

  // Receive sampler
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_enable) begin
      rx_st <= ST_IDLE;
      rx_cnt <= 4'h0;
      rx_idx <= 3'h0;
      rx_prev <= 1'b1;
      rx_x <= 1'b0;
      rx_shift_reg <= DATA_RST;
    end else if (tick) begin
      rx_prev <= line.rx_data_pin;
      rx_cnt <= rx_cnt + 4'h1;
      case (rx_st)
        ST_IDLE: begin
          if (rx_prev && !line.rx_data_pin && !err_any) begin
            rx_st <= ST_START;
            rx_cnt <= 4'h1;
          end
        end
        ST_START: begin
          if (rx_cnt == SAMPLE_PH) begin
            rx_st <= line.rx_data_pin ? ST_IDLE : ST_DATA;
            rx_idx <= 3'h0;
          end
        end
        ST_DATA: begin
          if (rx_cnt == SAMPLE_PH) begin
            rx_shift_reg <= {line.rx_data_pin, rx_shift_reg[7:1]};
            rx_idx <= rx_idx + 3'h1;
            if (rx_idx == last_idx) rx_st <= extra_en ? ST_EXTRA : ST_STOP1;
          end
        end
        ST_EXTRA: begin
          if (rx_cnt == SAMPLE_PH) begin
            rx_x <= line.rx_data_pin;
            rx_st <= ST_STOP1;
          end
        end
        ST_STOP1: if (rx_cnt == SAMPLE_PH) rx_st <= ST_IDLE;
        default: rx_st <= ST_IDLE;
      endcase
    end
  end

  // Receive data and flags, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_reg <= DATA_RST;
      rx_buf_full <= 1'b0;
      overrun_flag <= 1'b0;
      frame_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      rx_mpb <= 1'b0;
    end else begin
      if (rx_end && !rx_buf_full) begin
        rx_data_reg <= rx_word;
        rx_mpb <= multiproc_format & rx_x;
      end
      if (rx_end && !rx_buf_full && !ferr && !perr) rx_buf_full <= 1'b1;
      else if (wr_status && !w_data_q[SB_RX_FULL]) rx_buf_full <= 1'b0;
      if (rx_end && rx_buf_full) overrun_flag <= 1'b1;
      else if (wr_status && !w_data_q[SB_OVERRUN]) overrun_flag <= 1'b0;
      if (rx_end && !rx_buf_full && ferr) frame_error_flag <= 1'b1;
      else if (wr_status && !w_data_q[SB_FRAME]) frame_error_flag <= 1'b0;
      if (rx_end && !rx_buf_full && perr) parity_error_flag <= 1'b1;
      else if (wr_status && !w_data_q[SB_PARITY]) parity_error_flag <= 1'b0;
    end
  end

  // Interrupt requests as gated flag levels
  assign tx_empty_irq = ctrl[CB_TIE] && tx_buf_empty;
  assign tx_done_irq = ctrl[CB_TX_DONE_IRQ_EN] && tx_done_flag;
  assign rx_full_irq = ctrl[CB_RIE] && rx_buf_full;
  assign rx_error_irq = ctrl[CB_RIE] && err_any;

endmodule : asu_device
`default_nettype wire

// ==== verilog/asu_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface asu_if;
  logic tx_data_pin;
  logic rx_data_pin;
  logic sck_dev_out;
  logic sck_dev_oe;
  logic sck_far_out;
  logic sck_far_oe;
  logic serial_clock_pin;

  // Resolved clock pin level, pulled high when undriven
  assign serial_clock_pin = sck_dev_oe ? sck_dev_out : (sck_far_oe ? sck_far_out : 1'b1);

  modport device (
    output tx_data_pin, sck_dev_out, sck_dev_oe,
    input rx_data_pin, serial_clock_pin
  );
  modport partner (
    input tx_data_pin, serial_clock_pin,
    output rx_data_pin, sck_far_out, sck_far_oe
  );
endinterface : asu_if
`default_nettype wire

// ==== verilog/asu_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module asu_partner
  import asu_pkg::*;
#(
  parameter int unsigned TICK_DIV_P = TICK_DIV
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Frame format and external clock drive
  input wire logic cfg_seven,
  input wire logic cfg_par_en,
  input wire logic cfg_par_odd,
  input wire logic cfg_mpf,
  input wire logic cfg_two_stop,
  input wire logic cfg_mpb,
  input wire logic cfg_ext_clk,
  // Send stream
  input wire logic [7:0] send_data,
  input wire logic send_valid,
  output logic send_ready,
  // Receive stream
  output logic [7:0] recv_data,
  output logic recv_valid,
  output logic recv_frame_err,
  output logic recv_parity_err,
  // Serial line
  asu_if.partner line
);

  localparam int DW = $clog2(TICK_DIV_P + 1);

  logic [DW-1:0] div_cnt;
  logic tick, bit_end, rx_prev, tx_x, rx_x, sck_q;
  logic [3:0] ph, rx_cnt;
  logic [2:0] tx_idx, rx_idx;
  logic [7:0] tx_sh, rx_sh, rx_word;
  asu_state_t tx_st, rx_st;

  wire extra_en = cfg_par_en | cfg_mpf;
  wire [2:0] last_idx = cfg_seven ? 3'h6 : 3'h7;
  wire [7:0] tx_word = asu_word(send_data, cfg_seven);

  // Divider: 16x tick and free-running external clock
  assign tick = (div_cnt == DW'(TICK_DIV_P - 1));
  assign bit_end = tick && (ph == LAST_PH);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= '0;
      ph <= 4'h0;
      sck_q <= 1'b0;
    end else begin
      div_cnt <= tick ? '0 : div_cnt + 1'b1;
      if (tick) ph <= ph + 4'h1;
      sck_q <= (div_cnt < DW'(TICK_DIV_P / 2));
    end
  end
  assign line.sck_far_out = sck_q;
  assign line.sck_far_oe = cfg_ext_clk;

  // Send handshake at a bit boundary
  assign send_ready = (tx_st == ST_IDLE) && bit_end;

  // Transmitter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st <= ST_IDLE;
      tx_sh <= DATA_RST;
      tx_idx <= 3'h0;
      tx_x <= 1'b1;
      line.rx_data_pin <= 1'b1;
    end else if (send_valid && send_ready) begin
      tx_st <= ST_START;
      tx_sh <= tx_word;
      tx_x <= cfg_mpf ? cfg_mpb : asu_par(tx_word, cfg_par_odd);
      line.rx_data_pin <= 1'b0;
    end else if (bit_end) begin
      case (tx_st)
        ST_START: begin
          tx_st <= ST_DATA;
          tx_idx <= 3'h0;
          line.rx_data_pin <= tx_sh[0];
        end
        ST_DATA: begin
          if (tx_idx == last_idx) begin
            tx_st <= extra_en ? ST_EXTRA : ST_STOP1;
            line.rx_data_pin <= extra_en ? tx_x : 1'b1;
          end else begin
            tx_idx <= tx_idx + 3'h1;
            line.rx_data_pin <= tx_sh[tx_idx + 3'h1];
          end
        end
        ST_EXTRA: begin
          tx_st <= ST_STOP1;
          line.rx_data_pin <= 1'b1;
        end
        ST_STOP1: tx_st <= cfg_two_stop ? ST_STOP2 : ST_IDLE;
        ST_STOP2: tx_st <= ST_IDLE;
        default: begin
          tx_st <= ST_IDLE;
          line.rx_data_pin <= 1'b1;
        end
      endcase
    end
  end

  // Receiver, centre sampled on own 16x tick
  assign rx_word = cfg_seven ? {1'b0, rx_sh[7:1]} : rx_sh;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st <= ST_IDLE;
      rx_cnt <= 4'h0;
      rx_idx <= 3'h0;
      rx_sh <= DATA_RST;
      rx_x <= 1'b0;
      rx_prev <= 1'b1;
      recv_valid <= 1'b0;
      recv_data <= DATA_RST;
      recv_frame_err <= 1'b0;
      recv_parity_err <= 1'b0;
    end else begin
      recv_valid <= 1'b0;
      if (tick) begin
        rx_prev <= line.tx_data_pin;
        rx_cnt <= rx_cnt + 4'h1;
        case (rx_st)
          ST_IDLE: if (rx_prev && !line.tx_data_pin) begin
            rx_st <= ST_START;
            rx_cnt <= 4'h1;
          end
          ST_START: if (rx_cnt == SAMPLE_PH) begin
            rx_st <= line.tx_data_pin ? ST_IDLE : ST_DATA;
            rx_idx <= 3'h0;
          end
          ST_DATA: if (rx_cnt == SAMPLE_PH) begin
            rx_sh <= {line.tx_data_pin, rx_sh[7:1]};
            rx_idx <= rx_idx + 3'h1;
            if (rx_idx == last_idx) rx_st <= extra_en ? ST_EXTRA : ST_STOP1;
          end
          ST_EXTRA: if (rx_cnt == SAMPLE_PH) begin
            rx_x <= line.tx_data_pin;
            rx_st <= ST_STOP1;
          end
          ST_STOP1: if (rx_cnt == SAMPLE_PH) begin
            rx_st <= ST_IDLE;
            recv_valid <= 1'b1;
            recv_data <= rx_word;
            recv_frame_err <= !line.tx_data_pin;
            recv_parity_err <= cfg_par_en && !cfg_mpf &&
              (asu_par(rx_word, cfg_par_odd) != rx_x);
          end
          default: rx_st <= ST_IDLE;
        endcase
      end
    end
  end

endmodule : asu_partner
`default_nettype wire

// ==== verilog/asu_pkg.sv ====
package asu_pkg;

  // Timing: oversampled bit clock
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BIT_RATE = 9600;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned TICK_DIV = CLK_HZ / (BIT_RATE * OVERSAMPLE);
  localparam logic [3:0] SAMPLE_PH = 4'h7;
  localparam logic [3:0] LAST_PH = 4'hF;

  // Register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_MODE = 5'h04;
  localparam logic [4:0] OFF_STATUS = 5'h08;
  localparam logic [4:0] OFF_TXDATA = 5'h0C;
  localparam logic [4:0] OFF_RXDATA = 5'h10;

  // Control register fields
  localparam int CB_TX_EN = 0;
  localparam int CB_RX_EN = 1;
  localparam int CB_TIE = 2;
  localparam int CB_TX_DONE_IRQ_EN = 3;
  localparam int CB_RIE = 4;
  localparam int CB_CKS_LO = 5;
  localparam int CB_CKS_HI = 6;

  // Mode register fields
  localparam int MB_SEVEN = 0;
  localparam int MB_PAR_EN = 1;
  localparam int MB_PAR_ODD = 2;
  localparam int MB_MPF = 3;
  localparam int MB_TWO_STOP = 4;
  localparam int MB_MPB = 5;

  // Status register fields
  localparam int SB_TX_EMPTY = 0;
  localparam int SB_TX_DONE = 1;
  localparam int SB_RX_FULL = 2;
  localparam int SB_OVERRUN = 3;
  localparam int SB_FRAME = 4;
  localparam int SB_PARITY = 5;
  localparam int SB_RX_MPB = 6;

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Clock source selection values
  localparam logic [1:0] CKS_INT_OUT = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_EXTRA = 3'b011,
    ST_STOP1 = 3'b100,
    ST_STOP2 = 3'b101
  } asu_state_t;

  // Character masked to 7 or 8 bits
  function automatic logic [7:0] asu_word(input logic [7:0] d, input logic seven);
    asu_word = seven ? {1'b0, d[6:0]} : d;
  endfunction : asu_word

  // Parity bit for even (0) or odd (1) selection
  function automatic logic asu_par(input logic [7:0] d, input logic odd);
    asu_par = (^d) ^ odd;
  endfunction : asu_par

endpackage : asu_pkg
